// >>> src/bdm_data_mem.sv
// banked data memory decoder with interrupt control and reset cause
`timescale 1ns/1ps
// Overview of operation
// - bank select bit steers bank 0 or 1
// - low 32 addresses of each bank are special
// - ram at 20h-7Fh (20h-6Fh in the 80 byte variant), big variant adds A0h-BFh
// - F0h-FFh share the bytes of 70h-7Fh in the 96 and 128 byte variants
// - ram is 80, 96 or 128 bytes
// - every location direct or through pointer
// - interrupt control is plain read write
// - interrupt control seen at 0Bh and 8Bh
// - flags set regardless of any enable
// - bit 7 gates every interrupt
// - reset cause flags tell resets apart
// - reset cause at 8Eh, bits 7-2 zero
// - power-on clears its flag, software sets
// - brown-out clears its flag, software sets
// - brown-out flag cleared to 0 after power-on
// - brown-out flag meaningless when detector off
module bdm_data_mem
   import bdm_pkg::*;
#(
   parameter int VARIANT = VAR_128
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [1:0] reset_kind,
   // core data access
   input  wire logic       acc_req,
   input  wire logic       acc_we,
   input  wire logic [6:0] acc_addr,
   input  wire logic [7:0] acc_wdata,
   output      logic [7:0] acc_rdata,
   output      logic       acc_rvalid,
   // core state used for addressing
   input  wire logic [7:0] core_status,
   input  wire logic [7:0] indirect_pointer_reg,
   // other special registers outside this block
   output      logic       sfr_sel,
   output      logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_rdata,
   // interrupt events and request
   input  wire logic       timer_overflow_evt,
   input  wire logic       ext_pin_evt,
   input  wire logic       port_change_evt,
   input  wire logic       periph_irq_pending,
   output      logic       irq_request,
   // configuration word
   input  wire logic       brownout_detect_enable,
   // register views
   output      logic [7:0] interrupt_control_reg,
   output      logic [7:0] reset_cause_reg,
   output      logic       brownout_flag_valid
);
   bdm_ram_if ram_bus ();

   logic [7:0]        full_addr;
   logic              bank_select_bit;
   logic [6:0]        offset;
   logic              is_indirect;
   logic              hit_irq_ctrl;
   logic              hit_reset_cause;
   logic              hit_ram;
   logic              hit_sfr;
   logic [RAM_AW-1:0] ram_index;
   logic [7:0]        read_mux;
   logic [7:0]        next_irq_ctrl;
   logic [7:0]        next_reset_cause;
   logic [7:0]        next_rdata;
   logic              next_rvalid;
   logic              wr_strobe;

   // ram placement for a bank and offset; misses leave hit low
   function automatic logic [RAM_AW:0] ram_map(input logic bank,
                                               input logic [6:0] off);
      logic [RAM_AW:0] res;
      res = '0;
      if (!bank) begin
         if (off >= GPR_B0_FIRST && off <= GPR_B0_LAST &&
             (VARIANT != VAR_80 || off <= GPR_B0_LAST_SMALL)) begin
            res = {1'b1, off - GPR_B0_FIRST};
         end
      end else begin
         if (VARIANT != VAR_80 && off >= COMMON_FIRST &&
             off <= COMMON_LAST) begin
            res = {1'b1, off - GPR_B0_FIRST};
         end else if (VARIANT == VAR_128 && off >= GPR_B1_FIRST &&
                      off <= GPR_B1_LAST) begin
            res = {1'b1, off - GPR_B1_FIRST + GPR_B1_BASE};
         end
      end
      return res;
   endfunction : ram_map

   always_comb begin
      is_indirect     = (acc_addr == ADDR_INDIRECT[6:0]);
      bank_select_bit = core_status[BANK_SEL_POS];
      if (is_indirect) begin
         full_addr = indirect_pointer_reg;
      end else begin
         full_addr = {bank_select_bit, acc_addr};
      end
      offset = full_addr[6:0];
   end

   // address decode of the selected location
   always_comb begin
      logic [RAM_AW:0] map;
      map = ram_map(full_addr[7], offset);
      hit_irq_ctrl    = (full_addr == ADDR_IRQ_CTRL_B0) ||
                        (full_addr == ADDR_IRQ_CTRL_B1);
      hit_reset_cause = (full_addr == ADDR_RESET_CAUSE);
      hit_ram         = map[RAM_AW];
      ram_index       = map[RAM_AW-1:0];
      // low 32 of a bank are special
      hit_sfr         = (offset < SFR_SPAN) && !hit_irq_ctrl &&
                        !hit_reset_cause &&
                        (full_addr != ADDR_INDIRECT);
      wr_strobe       = acc_req & acc_we;
   end

   // ram array sized for the largest variant
   bdm_gpr_ram #(
      .WORDS    (RAM_WORDS)
   ) u_ram (
      .core_clk (core_clk),
      .rst      (rst),
      .port     (ram_bus.mem)
   );

   // ram access drive
   assign ram_bus.addr  = ram_index;
   assign ram_bus.we    = wr_strobe & hit_ram;
   assign ram_bus.wdata = acc_wdata;

   // other special registers are passed to the core side
   assign sfr_sel  = acc_req & hit_sfr;
   assign sfr_addr = full_addr;

   // interrupt control next value
   always_comb begin
      next_irq_ctrl = interrupt_control_reg;
      if (rst) begin
         next_irq_ctrl = IRQ_CTRL_RESET;
      end else begin
         if (wr_strobe && hit_irq_ctrl) begin
            next_irq_ctrl = acc_wdata;
         end
         if (timer_overflow_evt) begin
            next_irq_ctrl[IC_TIMER_FLAG] = 1'b1;
         end
         if (ext_pin_evt) begin
            next_irq_ctrl[IC_PIN_FLAG] = 1'b1;
         end
         if (port_change_evt) begin
            next_irq_ctrl[IC_PORT_FLAG] = 1'b1;
         end
      end
   end

   // interrupt control register
   always_ff @(posedge core_clk) begin
      interrupt_control_reg <= next_irq_ctrl;
   end

   assign irq_request = interrupt_control_reg[IC_GLOBAL_EN] & (
      (interrupt_control_reg[IC_TIMER_EN] &
       interrupt_control_reg[IC_TIMER_FLAG]) |
      (interrupt_control_reg[IC_PIN_EN] &
       interrupt_control_reg[IC_PIN_FLAG]) |
      (interrupt_control_reg[IC_PORT_EN] &
       interrupt_control_reg[IC_PORT_FLAG]) |
      (interrupt_control_reg[IC_PERIPH_EN] & periph_irq_pending));

   // reset cause next value
   always_comb begin
      next_reset_cause = reset_cause_reg & RC_IMPL_MASK;
      if (rst) begin
         unique case (reset_kind)
            // brown-out flag given a fixed value
            RST_POWER_ON: next_reset_cause = RESET_CAUSE_FIRST;
            RST_BROWN_OUT: next_reset_cause[RC_BROWN_OUT] = 1'b0;
            // pin and watchdog keep both flags
            RST_OTHER,
            RST_WATCHDOG: next_reset_cause = reset_cause_reg & RC_IMPL_MASK;
         endcase
      end else if (wr_strobe && hit_reset_cause) begin
         next_reset_cause = acc_wdata & RC_IMPL_MASK;
      end
   end

   // reset cause register, survives pin and watchdog resets
   always_ff @(posedge core_clk) begin
      reset_cause_reg <= next_reset_cause;
   end

   // flag only meaningful with detector on
   assign brownout_flag_valid = brownout_detect_enable;

   // read data select
   always_comb begin
      read_mux = 8'h00;
      if (hit_irq_ctrl) begin
         read_mux = interrupt_control_reg;
      end else if (hit_reset_cause) begin
         read_mux = reset_cause_reg & RC_IMPL_MASK;
      end else if (hit_ram) begin
         read_mux = ram_bus.rdata;
      end else if (hit_sfr) begin
         read_mux = sfr_rdata;
      end
   end

   // registered read answer, one cycle after the request
   always_comb begin
      next_rvalid = acc_req & ~acc_we & ~rst;
      next_rdata  = acc_rdata;
      if (rst) begin
         next_rdata = 8'h00;
      end else if (next_rvalid) begin
         next_rdata = read_mux;
      end
   end

   // read answer registers
   always_ff @(posedge core_clk) begin
      acc_rdata  <= next_rdata;
      acc_rvalid <= next_rvalid;
   end
endmodule : bdm_data_mem

// >>> src/bdm_gpr_ram.sv
// general purpose register file, byte wide static ram
`timescale 1ns/1ps
module bdm_gpr_ram
   import bdm_pkg::*;
#(
   parameter int WORDS = RAM_WORDS
) (
   // clock and reset
   input wire logic   core_clk,
   input wire logic   rst,
   // decoder side
   bdm_ram_if.mem     port
);
   logic [7:0] mem_array [WORDS];
   logic [7:0] next_word;
   logic       next_we;

   // write data for the addressed byte
   always_comb begin
      next_word = port.wdata;
      next_we   = port.we & ~rst;
   end

   // storage; contents are not cleared by reset
   always_ff @(posedge core_clk) begin
      if (next_we) begin
         mem_array[port.addr] <= next_word;
      end
   end

   // read is combinational; the decoder registers it
   assign port.rdata = mem_array[port.addr];
endmodule : bdm_gpr_ram

// >>> src/bdm_pkg.sv
// constants shared by the banked data memory block
package bdm_pkg;
   // address map
   localparam logic [7:0] ADDR_INDIRECT     = 8'h00;
   localparam logic [7:0] ADDR_IRQ_CTRL_B0  = 8'h0b;
   localparam logic [7:0] ADDR_IRQ_CTRL_B1  = 8'h8b;
   localparam logic [7:0] ADDR_RESET_CAUSE  = 8'h8e;
   localparam logic [6:0] SFR_SPAN          = 7'h20;
   localparam logic [6:0] GPR_B0_FIRST      = 7'h20;
   localparam logic [6:0] GPR_B0_LAST_SMALL = 7'h6f;
   localparam logic [6:0] GPR_B0_LAST       = 7'h7f;
   localparam logic [6:0] GPR_B1_FIRST      = 7'h20;
   localparam logic [6:0] GPR_B1_LAST       = 7'h3f;
   localparam logic [6:0] COMMON_FIRST      = 7'h70;
   localparam logic [6:0] COMMON_LAST       = 7'h7f;
   // index of the bank 1 block inside the ram array
   localparam logic [6:0] GPR_B1_BASE       = 7'h60;
   // core status field position
   localparam int         BANK_SEL_POS      = 5;
   // interrupt control field positions
   localparam int         IC_GLOBAL_EN      = 7;
   localparam int         IC_PERIPH_EN      = 6;
   localparam int         IC_TIMER_EN       = 5;
   localparam int         IC_PIN_EN         = 4;
   localparam int         IC_PORT_EN        = 3;
   localparam int         IC_TIMER_FLAG     = 2;
   localparam int         IC_PIN_FLAG       = 1;
   localparam int         IC_PORT_FLAG      = 0;
   // reset cause field positions
   localparam int         RC_POWER_ON       = 1;
   localparam int         RC_BROWN_OUT      = 0;
   localparam logic [7:0] RC_IMPL_MASK      = 8'h03;
   // reset values
   localparam logic [7:0] IRQ_CTRL_RESET    = 8'h00;
   localparam logic [7:0] RESET_CAUSE_FIRST = 8'h00;
   // variants: ram bytes per variant
   localparam int         VAR_80            = 0;
   localparam int         VAR_96            = 1;
   localparam int         VAR_128           = 2;
   localparam int         RAM_WORDS         = 128;
   localparam int         RAM_AW            = 7;
   // kind of reset reported while rst is high
   localparam logic [1:0] RST_OTHER         = 2'h0;
   localparam logic [1:0] RST_POWER_ON      = 2'h1;
   localparam logic [1:0] RST_BROWN_OUT     = 2'h2;
   localparam logic [1:0] RST_WATCHDOG      = 2'h3;
endpackage : bdm_pkg

// >>> src/bdm_ram_if.sv
// port bundle between the decoder and the general purpose ram
`timescale 1ns/1ps
interface bdm_ram_if;
   import bdm_pkg::*;
   logic [RAM_AW-1:0] addr;
   logic              we;
   logic [7:0]        wdata;
   logic [7:0]        rdata;
   modport ctrl (output addr, output we, output wdata, input rdata);
   modport mem  (input addr, input we, input wdata, output rdata);
endinterface : bdm_ram_if

// >>> verif/bdm_data_mem_bench.sv
// self-checking bench for the banked data memory block
`timescale 1ns/1ps
module bdm_data_mem_bench;
   import bdm_pkg::*;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic [1:0] kind = RST_POWER_ON;
   logic       req = 1'b0;
   logic       we = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] status = 8'h00;
   logic [7:0] ptr = 8'h00;
   logic [2:0] evt = 3'h0;
   logic       periph = 1'b0;
   logic       bod_en = 1'b1;
   logic [7:0] rdata, icr, rcr, sfr_addr, rd_val;
   logic       rvalid, sfr_sel, irq, bod_valid;
   int         n_mismatch = 0;
   int         samples_checked = 0;
   int         cycles = 0;

   bdm_data_mem #(.VARIANT(VAR_128)) dut (.core_clk(core_clk), .rst(rst),
      .reset_kind(kind), .acc_req(req), .acc_we(we), .acc_addr(addr),
      .acc_wdata(wdata), .acc_rdata(rdata), .acc_rvalid(rvalid),
      .core_status(status), .indirect_pointer_reg(ptr), .sfr_sel(sfr_sel),
      .sfr_addr(sfr_addr),
      .sfr_rdata(sfr_sel ? (sfr_addr ^ 8'h6e) : 8'h00),
      .timer_overflow_evt(evt[2]),
      .ext_pin_evt(evt[1]), .port_change_evt(evt[0]),
      .periph_irq_pending(periph), .irq_request(irq),
      .brownout_detect_enable(bod_en), .interrupt_control_reg(icr),
      .reset_cause_reg(rcr), .brownout_flag_valid(bod_valid));

   // clock and hang guard
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one access, bank chosen through the status byte
   task automatic acc(input logic bank, input logic w, input logic [6:0] a,
                      input logic [7:0] d);
      @(posedge core_clk);
      status <= {2'h0, bank, 5'h00};
      req <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      req <= 1'b0;
      #1;
      if (!w) begin
         chk({7'h00, rvalid}, 8'h01);
         rd_val = rdata;
      end
   endtask : acc

   task automatic wr(input logic bank, input logic [6:0] a, input logic [7:0] d);
      acc(bank, 1'b1, a, d);
   endtask : wr

   task automatic rd(input logic bank, input logic [6:0] a, input logic [7:0] e);
      acc(bank, 1'b0, a, 8'h00);
      chk(rd_val, e);
   endtask : rd

   task automatic do_rst(input logic [1:0] k);
      @(posedge core_clk);
      rst <= 1'b1;
      kind <= k;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
   endtask : do_rst

   task automatic pulse(input logic [2:0] m);
      @(posedge core_clk);
      evt <= m;
      @(posedge core_clk);
      evt <= 3'h0;
   endtask : pulse

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   // main sequence
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(1'b0, 7'h0b, 8'h00);
      rd(1'b1, 7'h0e, 8'h00);
      wr(1'b1, 7'h0e, 8'hff);
      rd(1'b1, 7'h0e, 8'h03);
      $display("test reset_values done");
      wr(1'b0, 7'h20, 8'h5a);
      wr(1'b0, 7'h7f, 8'ha5);
      wr(1'b1, 7'h20, 8'h3c);
      wr(1'b1, 7'h71, 8'h11);
      rd(1'b0, 7'h20, 8'h5a);
      rd(1'b1, 7'h20, 8'h3c);
      rd(1'b1, 7'h7f, 8'ha5);
      rd(1'b0, 7'h71, 8'h11);
      rd(1'b1, 7'h40, 8'h00);
      rd(1'b0, 7'h05, 8'h6b);
      @(posedge core_clk) ptr <= 8'ha0;
      rd(1'b0, 7'h00, 8'h3c);
      @(posedge core_clk) ptr <= 8'h21;
      wr(1'b1, 7'h00, 8'h77);
      rd(1'b0, 7'h21, 8'h77);
      $display("test memory_map done");
      wr(1'b0, 7'h0b, 8'ha5);
      chk({7'h00, irq}, 8'h01);
      rd(1'b1, 7'h0b, 8'ha5);
      wr(1'b1, 7'h0b, 8'h24);
      chk({7'h00, irq}, 8'h00);
      wr(1'b0, 7'h0b, 8'h00);
      for (int i = 0; i < 3; i++) begin
         pulse(3'h4 >> i);
         rd(1'b0, 7'h0b, 8'h04 >> i);
         chk({7'h00, irq}, 8'h00);
         wr(1'b0, 7'h0b, 8'h00);
         rd(1'b1, 7'h0b, 8'h00);
      end
      @(posedge core_clk) periph <= 1'b1;
      wr(1'b0, 7'h0b, 8'hc0);
      chk({7'h00, irq}, 8'h01);
      wr(1'b0, 7'h0b, 8'h80);
      chk({7'h00, irq}, 8'h00);
      @(posedge core_clk) periph <= 1'b0;
      $display("test interrupt_control done");
      do_rst(RST_BROWN_OUT);
      rd(1'b1, 7'h0e, 8'h02);
      wr(1'b1, 7'h0e, 8'h03);
      do_rst(RST_WATCHDOG);
      rd(1'b1, 7'h0e, 8'h03);
      do_rst(RST_POWER_ON);
      rd(1'b1, 7'h0e, 8'h00);
      rd(1'b0, 7'h20, 8'h5a);
      @(posedge core_clk) bod_en <= 1'b0;
      #1 chk({7'h00, bod_valid}, 8'h00);
      $display("test reset_cause done");
      stop_test();
   end
endmodule : bdm_data_mem_bench

// >>> verif/bdm_data_mem_sva.sv
// concurrent checks on the ports of the banked data memory block
`timescale 1ns/1ps
module bdm_chk
   import bdm_pkg::*;
(
   // clock and reset
   input logic       core_clk,
   input logic       rst,
   input logic [1:0] reset_kind,
   // core access
   input logic       acc_req,
   input logic       acc_we,
   input logic       acc_rvalid,
   input logic       sfr_sel,
   // interrupts
   input logic       timer_overflow_evt,
   input logic       ext_pin_evt,
   input logic       port_change_evt,
   input logic       periph_irq_pending,
   input logic       irq_request,
   // register views
   input logic       brownout_detect_enable,
   input logic       brownout_flag_valid,
   input logic [7:0] interrupt_control_reg,
   input logic [7:0] reset_cause_reg
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic [7:0] ic = interrupt_control_reg;
   a_read_answer: assert property (acc_req && !acc_we |=> acc_rvalid)
      else $error("read not answered next cycle");
   a_no_stray_valid: assert property (!(acc_req && !acc_we) |=> !acc_rvalid)
      else $error("answer without read");
   a_cause_high_zero: assert property (reset_cause_reg[7:2] == 6'h00)
      else $error("reset cause upper bits set");
   a_irq_ctrl_reset: assert property ($fell(rst) |-> ic == IRQ_CTRL_RESET)
      else $error("interrupt control not cleared by reset");
   a_timer_flag_set: assert property (timer_overflow_evt |=> ic[2])
      else $error("timer flag not set");
   a_pin_flag_set: assert property (ext_pin_evt |=> ic[1])
      else $error("pin flag not set");
   a_port_flag_set: assert property (port_change_evt |=> ic[0])
      else $error("port flag not set");
   a_irq_gate_exact: assert property (irq_request == (ic[7] &&
      ((ic[5] && ic[2]) || (ic[4] && ic[1]) || (ic[3] && ic[0]) ||
       (ic[6] && periph_irq_pending)))) else $error("irq request wrong");
   a_flag_sticky: assert property (!acc_req && ic[2] |=> ic[2])
      else $error("timer flag cleared by itself");
   a_cause_power: assert property ($fell(rst) &&
      $past(reset_kind) == RST_POWER_ON |-> reset_cause_reg == RESET_CAUSE_FIRST)
      else $error("power-on flag not cleared");
   a_cause_brown: assert property ($fell(rst) &&
      $past(reset_kind) == RST_BROWN_OUT |-> !reset_cause_reg[0])
      else $error("brown-out flag not cleared");
   a_bod_valid_tie: assert property (brownout_flag_valid == brownout_detect_enable)
      else $error("brown-out validity wrong");
   a_sfr_quiet: assert property (!acc_req |-> !sfr_sel)
      else $error("special select without request");
endmodule : bdm_chk

bind bdm_data_mem bdm_chk u_chk (.core_clk, .rst, .reset_kind, .acc_req, .acc_we,
   .acc_rvalid, .sfr_sel, .timer_overflow_evt, .ext_pin_evt, .port_change_evt,
   .periph_irq_pending, .irq_request, .brownout_detect_enable,
   .brownout_flag_valid, .interrupt_control_reg, .reset_cause_reg);
